/* File: core/pm_link_defs.svh */
// pm_link_defs.svh: offsets, fields, reset values and timing counts
// assumes the including file has `timescale set where needed
`ifndef PM_LINK_DEFS_SVH
`define PM_LINK_DEFS_SVH

// clock period of clk_sys in ns (200 MHz)
`define CLK_PERIOD_NS      5
// idle interval before standby entry, ns; least time, rounded up
`define IDLE_TIME_NS       6000
`define IDLE_CYCLES        ((`IDLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// request pin sample period, ns
`define PME_SAMPLE_NS      100000
`define PME_SAMPLE_CYCLES  (`PME_SAMPLE_NS / `CLK_PERIOD_NS)

// configuration register indices on the link
`define CFG_CMD            2'h0
`define CFG_PMCSR          2'h1
`define CFG_LNKCTL         2'h2
`define CFG_LNKCAP         2'h3

// command register fields
`define CMD_IO_BIT         0
`define CMD_MEM_BIT        1
`define CMD_BM_BIT         2
// power management control/status fields
`define PMCSR_PS_LSB       0
`define PMCSR_NSR_BIT      3
`define PS_D0              2'h0
`define PS_D1              2'h1
`define PS_D2              2'h2
`define PS_D3HOT           2'h3
// link control: standby entry enable is bit 0 of the two-bit field
`define LNKCTL_L0S_BIT     0
// link capabilities: standby-only support in bits 11:10
`define LNKCAP_VALUE       16'h0400

`define CMD_RESET          3'h0
`define LNKCTL_RESET       2'h0

`endif

/* File: core/pm_link_pkg.sv */
// pm_link_pkg: shared types of the link power manager
// assumes nothing beyond a SystemVerilog compiler
package pm_link_pkg;

    typedef enum logic [2:0] {
        LINK_L0,
        LINK_L0S,
        LINK_L1,
        LINK_L23RDY
    } link_state_t;

    typedef enum logic [1:0] {
        DEV_D0_UNINIT,
        DEV_D0_ACTIVE,
        DEV_D3_HOT
    } dev_state_t;

endpackage : pm_link_pkg

/* File: core/pm_link_if.sv */
// pm_link_if: abstract upstream link between bridge and root complex
// assumes both ends run on the same clk_sys
`timescale 1ns/10ps
`default_nettype none

interface pm_link_if;
    logic                      cfg_wr;      // config write pulse
    logic                      cfg_rd;      // config read pulse
    logic [1:0]                cfg_addr;    // register index
    logic [15:0]               cfg_wdata;   // write data
    logic [15:0]               cfg_rdata;   // read data
    logic                      cfg_ack;     // completion pulse
    logic                      turnoff;     // turn-off broadcast pulse
    logic                      exit_l1;     // upstream starts L1 exit
    logic                      host_pkt;    // upstream packet pulse
    pm_link_pkg::link_state_t  link_state;  // device link state
    logic                      pme_msg;     // power event message pulse
    logic                      turnoff_ack; // turn-off reply pulse
    logic                      dev_pkt;     // device packet pulse

    modport dev (
        input  cfg_wr, cfg_rd, cfg_addr, cfg_wdata, turnoff, exit_l1,
               host_pkt,
        output cfg_rdata, cfg_ack, link_state, pme_msg, turnoff_ack,
               dev_pkt
    );
    modport host (
        output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, turnoff, exit_l1,
               host_pkt,
        input  cfg_rdata, cfg_ack, link_state, pme_msg, turnoff_ack,
               dev_pkt
    );
endinterface : pm_link_if

`default_nettype wire

/* File: core/pm_interval_timer.sv */
// pm_interval_timer: counts cycles, flags when the count is reached
// assumes clear and run come from logic on clk_sys
`timescale 1ns/10ps
`default_nettype none

module pm_interval_timer #(
    parameter int CYCLES = 1200
) (
    input  wire logic clk_sys,  // system clock
    input  wire logic rst_n,    // sync reset, active low
    input  wire logic clear,    // restart the count
    input  wire logic run,      // count while high
    output logic      expired   // high once CYCLES reached
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES);

    logic [W-1:0] cnt_ff;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || clear || !run) begin
            cnt_ff <= '0;
        end else if (cnt_ff != LAST) begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end

    assign expired = run && (cnt_ff == LAST);
endmodule : pm_interval_timer

`default_nettype wire

/* File: core/pm_dev_end.sv */
// pm_dev_end: bridge power manager, device power state and link states
// assumes the upstream end keeps its own part of the link protocol
`timescale 1ns/10ps
`default_nettype none
`include "pm_link_defs.svh"

module pm_dev_end #(
    parameter int SAMPLE_CYCLES = `PME_SAMPLE_CYCLES
) (
    input  wire logic             clk_sys,        // system clock
    input  wire logic             rst_n,          // sync reset, active low
    pm_link_if.dev                link,           // upstream link
    input  wire logic             tx_pending,     // packet waiting to go
    input  wire logic             pme_req_n,      // secondary request pin
    output logic                  tx_grant,       // packet may go now
    output logic [1:0]            sec_clk_en,     // secondary clocks on
    output logic                  sec_rst_n,      // secondary bus reset
    output logic                  sec_bus_active, // bus takes part
    output pm_link_pkg::dev_state_t dev_state,    // device power state
    output logic                  no_soft_rst     // flag set on D3 to D0
);
    pm_link_pkg::link_state_t link_ff;
    pm_link_pkg::dev_state_t  dstate_ff;
    logic [2:0]  cmd_ff;
    logic [1:0]  lnkctl_ff;
    logic        nsr_ff;
    logic        pme_pend_ff;
    logic        toff_pend_ff;
    logic        req_meta_ff;
    logic        req_sync_ff;
    logic        ack_ff;
    logic [15:0] rdata_ff;
    logic        pme_msg_ff;
    logic        toff_ack_ff;
    logic        dev_pkt_ff;
    logic        grant_ff;
    logic [1:0]  clk_en_ff;
    logic        sec_rst_n_ff;
    logic        bus_act_ff;

    logic        cfg_req;
    logic        in_l23;
    logic        idle_hit;
    logic        sample_tick;
    logic        want_l0;
    logic        pkt_sent;
    logic        msg_slot;
    pm_link_pkg::link_state_t nxt_link;

    // packets never leave in L0s, L1 or L2/L3 ready
    function automatic logic can_tx(pm_link_pkg::link_state_t s);
        return s == pm_link_pkg::LINK_L0;
    endfunction : can_tx

    assign cfg_req = (link.cfg_wr || link.cfg_rd) && !in_l23;
    assign in_l23  = link_ff == pm_link_pkg::LINK_L23RDY;
    assign pkt_sent = dev_pkt_ff || pme_msg_ff || toff_ack_ff || ack_ff;
    // something must go upstream: return the link to L0
    assign want_l0 = tx_pending || pme_pend_ff || toff_pend_ff
                     || cfg_req || grant_ff || link.exit_l1;
    assign msg_slot = can_tx(link_ff) && !ack_ff && !cfg_req && !grant_ff;

    pm_interval_timer #(
        .CYCLES (`IDLE_CYCLES)
    ) u_idle (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clear   (pkt_sent || link.host_pkt),
        .run     (can_tx(link_ff) && lnkctl_ff[`LNKCTL_L0S_BIT]),
        .expired (idle_hit)
    );

    pm_interval_timer #(
        .CYCLES (SAMPLE_CYCLES - 1)
    ) u_sample (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clear   (sample_tick),
        .run     (1'b1),
        .expired (sample_tick)
    );

    // request pin crosses into clk_sys
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            req_meta_ff <= 1'b1;
            req_sync_ff <= 1'b1;
        end else begin
            req_meta_ff <= pme_req_n;
            req_sync_ff <= req_meta_ff;
        end
    end

    // link state machine
    always_comb begin
        nxt_link = link_ff;
        case (link_ff)
            pm_link_pkg::LINK_L0: begin
                if (toff_pend_ff && msg_slot) begin
                    nxt_link = pm_link_pkg::LINK_L23RDY;
                end else if (dstate_ff == pm_link_pkg::DEV_D3_HOT
                             && !want_l0 && !link.host_pkt) begin
                    nxt_link = pm_link_pkg::LINK_L1;
                end else if (idle_hit && !want_l0
                             && dstate_ff != pm_link_pkg::DEV_D3_HOT) begin
                    nxt_link = pm_link_pkg::LINK_L0S;
                end
            end
            pm_link_pkg::LINK_L0S: begin
                if (want_l0) begin
                    nxt_link = pm_link_pkg::LINK_L0;
                end else if (dstate_ff == pm_link_pkg::DEV_D3_HOT) begin
                    nxt_link = pm_link_pkg::LINK_L1;
                end
            end
            pm_link_pkg::LINK_L1: begin
                if (want_l0 || link.exit_l1) begin
                    nxt_link = pm_link_pkg::LINK_L0;
                end
            end
            pm_link_pkg::LINK_L23RDY: nxt_link = link_ff;
            default: nxt_link = pm_link_pkg::LINK_L0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            link_ff <= pm_link_pkg::LINK_L0;
        end else begin
            link_ff <= nxt_link;
        end
    end

    // device power state, changed only by config writes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dstate_ff <= pm_link_pkg::DEV_D0_UNINIT;
            cmd_ff    <= `CMD_RESET;
            lnkctl_ff <= `LNKCTL_RESET;
            nsr_ff    <= 1'b0;
        end else if (link.cfg_wr && !in_l23) begin
            case (link.cfg_addr)
                `CFG_CMD: begin
                    cmd_ff <= link.cfg_wdata[2:0];
                    if (dstate_ff == pm_link_pkg::DEV_D0_UNINIT
                        && link.cfg_wdata[2:0] != 3'h0) begin
                        dstate_ff <= pm_link_pkg::DEV_D0_ACTIVE;
                    end
                end
                `CFG_PMCSR: begin
                    case (link.cfg_wdata[`PMCSR_PS_LSB +: 2])
                        `PS_D3HOT: dstate_ff <= pm_link_pkg::DEV_D3_HOT;
                        `PS_D0: begin
                            if (dstate_ff == pm_link_pkg::DEV_D3_HOT) begin
                                dstate_ff <= pm_link_pkg::DEV_D0_UNINIT;
                                nsr_ff    <= 1'b1;
                            end
                        end
                        default: dstate_ff <= dstate_ff;
                    endcase
                end
                `CFG_LNKCTL: lnkctl_ff <= link.cfg_wdata[1:0];
                default: cmd_ff <= cmd_ff;
            endcase
        end
    end

    // config completions, one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            ack_ff   <= cfg_req;
            rdata_ff <= 16'h0000;
            if (link.cfg_rd && !in_l23) begin
                case (link.cfg_addr)
                    `CFG_CMD:    rdata_ff <= {13'h0000, cmd_ff};
                    `CFG_PMCSR:  rdata_ff <= {12'h000, nsr_ff, 1'b0,
                        (dstate_ff == pm_link_pkg::DEV_D3_HOT)
                        ? `PS_D3HOT : `PS_D0};
                    `CFG_LNKCTL: rdata_ff <= {14'h0000, lnkctl_ff};
                    default:     rdata_ff <= `LNKCAP_VALUE;
                endcase
            end
        end
    end

    // power event and turn-off bookkeeping
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pme_pend_ff  <= 1'b0;
            toff_pend_ff <= 1'b0;
            pme_msg_ff   <= 1'b0;
            toff_ack_ff  <= 1'b0;
        end else begin
            pme_msg_ff  <= 1'b0;
            toff_ack_ff <= 1'b0;
            if (link.turnoff && !in_l23) begin
                toff_pend_ff <= 1'b1;
            end else if (toff_pend_ff && msg_slot) begin
                toff_pend_ff <= 1'b0;
                toff_ack_ff  <= 1'b1;
            end
            if (sample_tick && !req_sync_ff && !in_l23) begin
                pme_pend_ff <= 1'b1;
            end else if (pme_pend_ff && msg_slot && !toff_pend_ff) begin
                pme_pend_ff <= 1'b0;
                pme_msg_ff  <= 1'b1;
            end
        end
    end

    // transmit permission and secondary bus controls
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            grant_ff     <= 1'b0;
            dev_pkt_ff   <= 1'b0;
            clk_en_ff    <= 2'b00;
            sec_rst_n_ff <= 1'b0;
            bus_act_ff   <= 1'b0;
        end else begin
            grant_ff   <= tx_pending && msg_slot && !pme_pend_ff
                          && !toff_pend_ff && !grant_ff;
            dev_pkt_ff <= grant_ff;
            clk_en_ff  <= in_l23 ? 2'b00 : 2'b11;
            sec_rst_n_ff <= 1'b1;
            bus_act_ff <= dstate_ff != pm_link_pkg::DEV_D3_HOT
                          && !in_l23;
        end
    end

    assign link.cfg_ack     = ack_ff;
    assign link.cfg_rdata   = rdata_ff;
    assign link.link_state  = link_ff;
    assign link.pme_msg     = pme_msg_ff;
    assign link.turnoff_ack = toff_ack_ff;
    assign link.dev_pkt     = dev_pkt_ff;
    assign tx_grant         = grant_ff;
    assign sec_clk_en       = clk_en_ff;
    assign sec_rst_n        = sec_rst_n_ff;
    assign sec_bus_active   = bus_act_ff;
    assign dev_state        = dstate_ff;
    assign no_soft_rst      = nsr_ff;
endmodule : pm_dev_end

`default_nettype wire

/* File: core/pm_host_end.sv */
// pm_host_end: upstream end, drives config, turn-off and L1 exit
// assumes user requests are single-cycle pulses on clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "pm_link_defs.svh"

module pm_host_end (
    input  wire logic        clk_sys,     // system clock
    input  wire logic        rst_n,       // sync reset, active low
    pm_link_if.host          link,        // link to the bridge
    input  wire logic        req_wr,      // config write request
    input  wire logic        req_rd,      // config read request
    input  wire logic [1:0]  req_addr,    // register index
    input  wire logic [15:0] req_wdata,   // write data
    input  wire logic        req_turnoff, // broadcast turn-off
    input  wire logic        req_pkt,     // send a packet
    output logic             rsp_valid,   // completion seen
    output logic [15:0]      rsp_rdata,   // completion data
    output logic             pme_seen,    // power event message seen
    output logic             ack_seen,    // turn-off reply seen
    output logic             pkt_stall    // packet held back
);
    logic        wr_ff;
    logic        rd_ff;
    logic [1:0]  addr_ff;
    logic [15:0] wdata_ff;
    logic        toff_ff;
    logic        exit_ff;
    logic        pkt_ff;
    logic        hold_ff;
    logic        valid_ff;
    logic [15:0] rdata_ff;
    logic        pme_ff;
    logic        ack_ff;
    logic        link_ok;

    // upstream packets go only with the link in L0 or L0s
    assign link_ok = link.link_state != pm_link_pkg::LINK_L1
                     && link.link_state != pm_link_pkg::LINK_L23RDY;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ff    <= 1'b0;
            rd_ff    <= 1'b0;
            addr_ff  <= 2'h0;
            wdata_ff <= 16'h0000;
            toff_ff  <= 1'b0;
        end else begin
            wr_ff    <= req_wr;
            rd_ff    <= req_rd;
            addr_ff  <= req_addr;
            wdata_ff <= req_wdata;
            toff_ff  <= req_turnoff;
        end
    end

    // packets wait in L1, with an exit started from this end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hold_ff <= 1'b0;
            pkt_ff  <= 1'b0;
            exit_ff <= 1'b0;
        end else begin
            pkt_ff  <= 1'b0;
            exit_ff <= 1'b0;
            if ((req_pkt || hold_ff) && link_ok) begin
                pkt_ff  <= 1'b1;
                hold_ff <= 1'b0;
            end else if (req_pkt || hold_ff) begin
                hold_ff <= link.link_state != pm_link_pkg::LINK_L23RDY;
                exit_ff <= link.link_state == pm_link_pkg::LINK_L1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            valid_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            pme_ff   <= 1'b0;
            ack_ff   <= 1'b0;
        end else begin
            valid_ff <= link.cfg_ack;
            if (link.cfg_ack) begin
                rdata_ff <= link.cfg_rdata;
            end
            pme_ff <= link.pme_msg;
            ack_ff <= link.turnoff_ack;
        end
    end

    assign link.cfg_wr    = wr_ff;
    assign link.cfg_rd    = rd_ff;
    assign link.cfg_addr  = addr_ff;
    assign link.cfg_wdata = wdata_ff;
    assign link.turnoff   = toff_ff;
    assign link.exit_l1   = exit_ff;
    assign link.host_pkt  = pkt_ff;
    assign rsp_valid      = valid_ff;
    assign rsp_rdata      = rdata_ff;
    assign pme_seen       = pme_ff;
    assign ack_seen       = ack_ff;
    assign pkt_stall      = hold_ff;
endmodule : pm_host_end

`default_nettype wire

/* File: verification/pm_link_checker.sv */
// pm_link_checker: timing relations on the upstream link signals
// assumes one clk_sys domain and rst_n synchronous, active low
`timescale 1ns/10ps
`default_nettype none
`include "pm_link_defs.svh"

module pm_link_checker (
    input wire logic                     clk_sys,     // clock
    input wire logic                     rst_n,       // reset
    input wire logic                     cfg_wr,      // write
    input wire logic                     cfg_rd,      // read
    input wire logic [1:0]               cfg_addr,    // index
    input wire logic [15:0]              cfg_wdata,   // wdata
    input wire logic [15:0]              cfg_rdata,   // rdata
    input wire logic                     cfg_ack,     // ack
    input wire logic                     turnoff,     // turn-off
    input wire logic                     host_pkt,    // host pkt
    input wire pm_link_pkg::link_state_t link_state,  // state
    input wire logic                     pme_msg,     // event msg
    input wire logic                     turnoff_ack, // reply
    input wire logic                     dev_pkt      // dev pkt
);
    logic [15:0] idle_ff;
    logic        d3_ff;
    logic        busy;

    assign busy = dev_pkt | pme_msg | turnoff_ack | cfg_ack | host_pkt;

    // quiet cycles spent in L0
    always_ff @(posedge clk_sys) begin
        if (!rst_n || busy || link_state != pm_link_pkg::LINK_L0)
            idle_ff <= 16'h0000;
        else if (idle_ff != 16'hFFFF)
            idle_ff <= idle_ff + 16'h0001;
    end

    // software has asked for D3hot
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            d3_ff <= 1'h0;
        else if (cfg_wr && cfg_addr == `CFG_PMCSR
                 && link_state != pm_link_pkg::LINK_L23RDY) begin
            if (cfg_wdata[1:0] == `PS_D3HOT)
                d3_ff <= 1'h1;
            else if (cfg_wdata[1:0] == `PS_D0)
                d3_ff <= 1'h0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_no_pkt_standby: assert property (
        link_state == pm_link_pkg::LINK_L0S |-> !dev_pkt)
        else $error("device packet sent in standby");
    a_quiet_l1: assert property (
        link_state == pm_link_pkg::LINK_L1
        |-> !dev_pkt && !pme_msg && !turnoff_ack && !host_pkt)
        else $error("traffic while in L1");
    a_quiet_l23: assert property (
        link_state == pm_link_pkg::LINK_L23RDY
        |-> !dev_pkt && !pme_msg && !cfg_ack ##1
        link_state == pm_link_pkg::LINK_L23RDY)
        else $error("traffic or exit after turn-off");
    a_turnoff_reply: assert property (
        turnoff |-> ##[1:6] turnoff_ack)
        else $error("no reply to turn-off");
    a_pme_from_l0: assert property (
        pme_msg |-> link_state == pm_link_pkg::LINK_L0)
        else $error("event message outside L0");
    a_cfg_answer: assert property (
        (cfg_wr || cfg_rd) && link_state != pm_link_pkg::LINK_L23RDY
        |=> cfg_ack)
        else $error("config access not completed");
    a_cap_value: assert property (
        cfg_rd && cfg_addr == `CFG_LNKCAP
        && link_state != pm_link_pkg::LINK_L23RDY
        |=> cfg_rdata == `LNKCAP_VALUE)
        else $error("link capability value wrong");
    a_l1_entry: assert property (
        cfg_wr && cfg_addr == `CFG_PMCSR && cfg_wdata[1:0] == `PS_D3HOT
        && link_state != pm_link_pkg::LINK_L23RDY
        |-> ##[1:3] link_state == pm_link_pkg::LINK_L1)
        else $error("no L1 entry after D3hot write");
    a_l1_by_sw: assert property (
        link_state == pm_link_pkg::LINK_L1 |-> d3_ff)
        else $error("L1 without D3hot");
    a_standby_idle: assert property (
        link_state == pm_link_pkg::LINK_L0
        ##1 link_state == pm_link_pkg::LINK_L0S
        |-> idle_ff > 16'(`IDLE_CYCLES))
        else $error("standby entered too early");
endmodule : pm_link_checker

`default_nettype wire

/* File: verification/test_bridge_link_power_manager.sv */
// test_bridge_link_power_manager: both ends joined over the link
// assumes design files and the link checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "pm_link_defs.svh"

module test_bridge_link_power_manager;
    localparam int          SMP  = 40;
    // read value when no completion came back
    localparam logic [15:0] NONE = 16'hFFFF;

    logic        clk_sys, rst_n = 1'h0, tx_pending = 1'h0;
    logic        pme_req_n = 1'h1, req_wr = 1'h0, req_rd = 1'h0;
    logic        req_turnoff = 1'h0, req_pkt = 1'h0;
    logic [1:0]  req_addr = 2'h0;
    logic [15:0] req_wdata = 16'h0000, rsp_rdata, rd;
    logic [1:0]  sec_clk_en;
    logic        tx_grant, sec_rst_n, sec_bus_active, no_soft_rst;
    logic        rsp_valid, pme_seen, ack_seen, pkt_stall;
    int          fails = 0, cmp_count = 0, pme_cnt = 0;
    pm_link_pkg::dev_state_t dev_state;

    pm_link_if link ();

    pm_dev_end #(.SAMPLE_CYCLES(SMP)) pm_dev_end_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .tx_pending(tx_pending), .pme_req_n(pme_req_n),
        .tx_grant(tx_grant), .sec_clk_en(sec_clk_en),
        .sec_rst_n(sec_rst_n), .sec_bus_active(sec_bus_active),
        .dev_state(dev_state), .no_soft_rst(no_soft_rst));

    pm_host_end pm_host_end_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .req_wr(req_wr), .req_rd(req_rd), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_turnoff(req_turnoff),
        .req_pkt(req_pkt), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .pme_seen(pme_seen), .ack_seen(ack_seen), .pkt_stall(pkt_stall));

    pm_link_checker pm_link_checker_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .cfg_wr(link.cfg_wr),
        .cfg_rd(link.cfg_rd), .cfg_addr(link.cfg_addr),
        .cfg_wdata(link.cfg_wdata), .cfg_rdata(link.cfg_rdata),
        .cfg_ack(link.cfg_ack), .turnoff(link.turnoff),
        .host_pkt(link.host_pkt), .link_state(link.link_state),
        .pme_msg(link.pme_msg), .turnoff_ack(link.turnoff_ack),
        .dev_pkt(link.dev_pkt));

    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) if (pme_seen === 1'h1) pme_cnt++;

    function automatic logic [15:0] sv();
        return {11'h000, sec_clk_en, sec_rst_n, sec_bus_active, no_soft_rst};
    endfunction : sv

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cfg(input logic wr, input logic [1:0] a,
                       input logic [15:0] d, input logic [15:0] exp);
        @(negedge clk_sys);
        req_wr = wr;
        req_rd = !wr;
        req_addr = a;
        req_wdata = d;
        @(negedge clk_sys);
        req_wr = 1'h0;
        req_rd = 1'h0;
        rd = NONE;
        for (int i = 0; i < 8 && rd === NONE; i++) begin
            @(posedge clk_sys);
            #1;
            if (rsp_valid === 1'h1) rd = rsp_rdata;
        end
        chk(rd, exp);
        @(negedge clk_sys);
    endtask : cfg

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1'h1;
        repeat (3) @(negedge clk_sys);
        chk(16'(dev_state), 16'(pm_link_pkg::DEV_D0_UNINIT));
        chk(sv(), 16'h001E);
        cfg(1'h0, `CFG_LNKCAP, 16'h0000, `LNKCAP_VALUE);
        cfg(1'h0, `CFG_LNKCTL, 16'h0000, 16'h0000);
        repeat (1400) @(negedge clk_sys);
        chk(16'(link.link_state), 16'(pm_link_pkg::LINK_L0));
        cfg(1'h1, `CFG_CMD, 16'h0004, 16'h0000);
        chk(16'(dev_state), 16'(pm_link_pkg::DEV_D0_ACTIVE));
        for (int s = 1; s < 3; s++) begin
            cfg(1'h1, `CFG_PMCSR, 16'(s), 16'h0000);
            chk(16'(dev_state), 16'(pm_link_pkg::DEV_D0_ACTIVE));
        end
        $display("test done: reset and d-states");
        cfg(1'h1, `CFG_LNKCTL, 16'h0001, 16'h0000);
        repeat (1300) @(negedge clk_sys);
        chk(16'(link.link_state), 16'(pm_link_pkg::LINK_L0S));
        tx_pending = 1'h1;
        for (int i = 0; i < 20 && tx_grant !== 1'h1; i++)
            @(negedge clk_sys);
        tx_pending = 1'h0;
        chk({15'h0000, tx_grant}, 16'h0001);
        chk(16'(link.link_state), 16'(pm_link_pkg::LINK_L0));
        repeat (1300) @(negedge clk_sys);
        req_pkt = 1'h1;
        @(negedge clk_sys);
        req_pkt = 1'h0;
        repeat (3) @(negedge clk_sys);
        chk(16'(link.link_state), 16'(pm_link_pkg::LINK_L0S));
        $display("test done: standby");
        cfg(1'h1, `CFG_PMCSR, 16'(`PS_D3HOT), 16'h0000);
        repeat (3) @(negedge clk_sys);
        chk(16'(link.link_state), 16'(pm_link_pkg::LINK_L1));
        chk(sv(), 16'h001C);
        cfg(1'h0, `CFG_LNKCTL, 16'h0000, 16'h0001);
        req_pkt = 1'h1;
        @(negedge clk_sys);
        req_pkt = 1'h0;
        chk({15'h0000, pkt_stall}, 16'h0001);
        repeat (2) @(negedge clk_sys);
        chk(16'(link.link_state), 16'(pm_link_pkg::LINK_L0));
        pme_req_n = 1'h0;
        for (int i = 0; i < SMP + 10 && pme_cnt == 0; i++)
            @(negedge clk_sys);
        pme_req_n = 1'h1;
        chk(16'(pme_cnt), 16'h0001);
        cfg(1'h1, `CFG_PMCSR, 16'(`PS_D0), 16'h0000);
        chk(16'(dev_state), 16'(pm_link_pkg::DEV_D0_UNINIT));
        cfg(1'h0, `CFG_PMCSR, 16'h0000, 16'h0008);
        $display("test done: D3hot and event");
        cfg(1'h1, `CFG_PMCSR, 16'(`PS_D3HOT), 16'h0000);
        req_turnoff = 1'h1;
        @(negedge clk_sys);
        req_turnoff = 1'h0;
        for (int i = 0; i < 10 && ack_seen !== 1'h1; i++)
            @(negedge clk_sys);
        chk({15'h0000, ack_seen}, 16'h0001);
        chk(16'(link.link_state), 16'(pm_link_pkg::LINK_L23RDY));
        chk(sv(), 16'h0005);
        pme_req_n = 1'h0;
        repeat (3 * SMP) @(negedge clk_sys);
        chk(16'(pme_cnt), 16'h0001);
        cfg(1'h0, `CFG_LNKCAP, 16'h0000, NONE);
        $display("test done: turn-off");
        test_done;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        $display("[ERR] %0t watchdog timeout", $time);
        test_done;
    end
endmodule : test_bridge_link_power_manager

`default_nettype wire
